// file: verilog/socket_power_pkg.sv
package socket_power_pkg;
	localparam logic [11:0] ID_REV_OFFSET = 12'h800;
	localparam logic [11:0] IF_STATUS_OFFSET = 12'h801;
	localparam logic [11:0] POWER_CTRL_OFFSET = 12'h802;
	localparam logic [3:0] REV_OLDER = 4'h2;
	localparam logic [3:0] REV_RESET = 4'h4;
	localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
	localparam int POWERED_BIT = 6;
	// Writable masks per model
	localparam logic [7:0] OLDER_WMASK = 8'hb3;
	localparam logic [7:0] NEWER_WMASK = 8'h9b;
	typedef enum logic [1:0] {VCC_OFF, VCC_RESERVED_BITS, VCC_5V, VCC_3V3} vcc_sel_t;
	typedef enum logic [1:0] {VPP_NONE, VPP_VCC, VPP_12V, VPP_RESERVED_BITS} vpp_sel_t;
	typedef struct packed {
		logic outputEnable;
		vcc_sel_t vcc;
		vpp_sel_t vpp;
		logic autoSwitch;
	} switch_req_t;
endpackage

// file: verilog/pc_card_socket_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module pc_card_socket_power_control
	import socket_power_pkg::*;
(
	input wire logic clk, // 200 MHz
	input wire logic sys_rst, // Sync reset, high
	input wire logic [11:0] regAddr, // Socket register offset
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [7:0] regWdata, // Write data
	input wire logic sysAutoSwitchAllow, // System control bit 7
	input wire logic sysVccLevel3v3, // System control bit 2
	input wire logic [5:0] ifStatusIn, // Interface status bits 5-0
	output logic [7:0] regRdata, // Read data
	output logic cardOutputEnable, // Card outputs on
	output logic autoSwitchEn, // Auto power switching on
	output var vcc_sel_t vccLevelSelect, // Vcc to switch
	output var vpp_sel_t vppLevelSelect // Vpp to switch
);
	logic [3:0] revField_q;
	logic [7:0] powerCtrl_q;
	wire hitRev = regAddr == ID_REV_OFFSET;
	wire hitPower = regAddr == POWER_CTRL_OFFSET;
	wire hitStatus = regAddr == IF_STATUS_OFFSET;
	wire olderModel = revField_q == REV_OLDER;
	wire [7:0] wmask = olderModel ? OLDER_WMASK : NEWER_WMASK;
	// Stored bits outside the current model mask read zero
	wire [7:0] powerView = powerCtrl_q & wmask;
	wire vppRaw1 = powerView[1];
	wire vppRaw0 = powerView[0];
	wire [1:0] vppReq = {vppRaw1, vppRaw0};
	wire [1:0] oldVcc = sysVccLevel3v3 ? 2'h3 : 2'h2;
	// Older model: power enable plus system level choice
	wire [1:0] vccDec = olderModel ? (powerView[4] ? oldVcc : 2'h0)
		: powerView[4:3];
	wire vccOn = vccDec[1]; // reserved 01 counts as off
	wire [1:0] vppDec = vccOn ? vppReq : 2'h0;
	wire powered = vccOn;
	wire [7:0] statusView = {1'b0, powered, ifStatusIn};
	wire [7:0] revView = {4'h0, revField_q};
	wire [7:0] rdMux = hitPower ? powerView
		: hitStatus ? statusView
		: hitRev ? revView : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			revField_q <= REV_RESET;
			powerCtrl_q <= POWER_CTRL_RESET;
		end else if (regWr) begin
			if (hitRev)
				revField_q <= regWdata[3:0];
			if (hitPower)
				powerCtrl_q <= regWdata & wmask;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata <= 8'h00;
			cardOutputEnable <= 1'b0;
			autoSwitchEn <= 1'b0;
			vccLevelSelect <= VCC_OFF;
			vppLevelSelect <= VPP_NONE;
		end else begin
			regRdata <= regRd ? rdMux : 8'h00;
			cardOutputEnable <= powerView[7];
			autoSwitchEn <= olderModel & powerView[5] & sysAutoSwitchAllow;
			vccLevelSelect <= vcc_sel_t'(vccDec);
			vppLevelSelect <= vpp_sel_t'(vppDec);
		end
	end

	// Model taken at the read edge; a switch in that cycle lands later
	property p_reserved_zero;
		@(posedge clk) disable iff (sys_rst)
		regRd && hitPower |=> ($past(olderModel)
			? (regRdata & 8'h4c) == 8'h00
			: (regRdata & 8'h64) == 8'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("Reserved bit nonzero");

	property p_vpp_gated;
		@(posedge clk) disable iff (sys_rst)
		vccLevelSelect inside {VCC_OFF, VCC_RESERVED_BITS} |->
			vppLevelSelect == VPP_NONE;
	endproperty
	a_vpp_gated: assert property (p_vpp_gated)
		else $error("Vpp active with Vcc off");

	sequence s_power_write;
		regWr && hitPower && !olderModel;
	endsequence
	property p_new_vcc;
		@(posedge clk) disable iff (sys_rst)
		s_power_write ##1 !regWr |=>
			vccLevelSelect == vcc_sel_t'($past(regWdata[4:3], 2));
	endproperty
	a_new_vcc: assert property (p_new_vcc)
		else $error("Vcc not following write");

	property p_coe;
		@(posedge clk) disable iff (sys_rst)
		regWr && hitPower ##1 !regWr |=>
			cardOutputEnable == $past(regWdata[7], 2);
	endproperty
	a_coe: assert property (p_coe)
		else $error("Output enable wrong");

	property p_auto;
		@(posedge clk) disable iff (sys_rst)
		!olderModel |=> !autoSwitchEn;
	endproperty
	a_auto: assert property (p_auto)
		else $error("Auto switch in newer model");

	property p_powered;
		@(posedge clk) disable iff (sys_rst)
		regRd && hitStatus |=> regRdata[POWERED_BIT] == $past(powered);
	endproperty
	a_powered: assert property (p_powered)
		else $error("Powered flag wrong");

	property p_old_vcc;
		@(posedge clk) disable iff (sys_rst)
		olderModel && !powerView[4] |=> vccLevelSelect == VCC_OFF;
	endproperty
	a_old_vcc: assert property (p_old_vcc)
		else $error("Vcc on while disabled");

	property p_reset_val;
		@(posedge clk)
		sys_rst |=> powerCtrl_q == 8'h00 && revField_q == REV_RESET;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("Reset value wrong");

	property p_rev_write;
		@(posedge clk) disable iff (sys_rst)
		regWr && hitRev |=> revField_q == $past(regWdata[3:0]);
	endproperty
	a_rev_write: assert property (p_rev_write)
		else $error("Revision field not written");

	property p_model_switch;
		@(posedge clk) disable iff (sys_rst)
		regWr && hitRev && regWdata[3:0] == REV_OLDER |=> olderModel;
	endproperty
	a_model_switch: assert property (p_model_switch)
		else $error("Older model not selected");

	property p_rev_hold;
		@(posedge clk) disable iff (sys_rst)
		!(regWr && hitRev) |=> $stable(revField_q);
	endproperty
	a_rev_hold: assert property (p_rev_hold)
		else $error("Revision changed without write");

	property p_power_hold;
		@(posedge clk) disable iff (sys_rst)
		!(regWr && hitPower) |=> $stable(powerCtrl_q);
	endproperty
	a_power_hold: assert property (p_power_hold)
		else $error("Power register changed without write");

	// Bits hidden at the write are never stored; bits hidden later by a model switch stay stored
	property p_write_mask;
		@(posedge clk) disable iff (sys_rst)
		regWr && hitPower |=> (powerCtrl_q & ~$past(wmask)) == 8'h00;
	endproperty
	a_write_mask: assert property (p_write_mask)
		else $error("Read-only bit stored");

	property p_unmapped;
		@(posedge clk) disable iff (sys_rst)
		regRd && !hitPower && !hitStatus && !hitRev |=> regRdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped read not zero");

	property p_idle_read;
		@(posedge clk) disable iff (sys_rst)
		!regRd |=> regRdata == 8'h00;
	endproperty
	a_idle_read: assert property (p_idle_read)
		else $error("Read data without read");

	sequence s_status_read;
		regRd && hitStatus;
	endsequence
	property p_status_view;
		@(posedge clk) disable iff (sys_rst)
		s_status_read |=>
			!regRdata[7] && regRdata[5:0] == $past(ifStatusIn);
	endproperty
	a_status_view: assert property (p_status_view)
		else $error("Status bits wrong");

	property p_old_level;
		@(posedge clk) disable iff (sys_rst)
		olderModel && powerView[4] |=> vccLevelSelect ==
			($past(sysVccLevel3v3) ? VCC_3V3 : VCC_5V);
	endproperty
	a_old_level: assert property (p_old_level)
		else $error("Older model Vcc level wrong");

	property p_auto_allow;
		@(posedge clk) disable iff (sys_rst)
		!sysAutoSwitchAllow |=> !autoSwitchEn;
	endproperty
	a_auto_allow: assert property (p_auto_allow)
		else $error("Auto switch without system allow");

	property p_vpp_follow;
		@(posedge clk) disable iff (sys_rst)
		vccOn |=> vppLevelSelect == vpp_sel_t'($past(powerView[1:0]));
	endproperty
	a_vpp_follow: assert property (p_vpp_follow)
		else $error("Vpp not following request");

	property p_new_vcc_reserved_bits;
		@(posedge clk) disable iff (sys_rst)
		!olderModel && powerView[4:3] == 2'h1 |=>
			vccLevelSelect == VCC_RESERVED_BITS && vppLevelSelect == VPP_NONE;
	endproperty
	a_new_vcc_reserved_bits: assert property (p_new_vcc_reserved_bits)
		else $error("Reserved Vcc code not off");

	property p_oe_off;
		@(posedge clk) disable iff (sys_rst)
		!powerView[7] |=> !cardOutputEnable;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("Outputs enabled while gated");

	// The Vcc output only moves when its sources moved one cycle earlier
	property p_vcc_stable;
		@(posedge clk) disable iff (sys_rst)
		$stable(powerCtrl_q) && $stable(revField_q)
			&& $stable(sysVccLevel3v3) |=> $stable(vccLevelSelect);
	endproperty
	a_vcc_stable: assert property (p_vcc_stable)
		else $error("Vcc output moved without cause");
endmodule
`default_nettype wire

// file: test/socket_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module socket_switch_model (
	input wire logic clk, // Clock
	input wire logic [1:0] vccIn, // Vcc request
	output logic [5:0] cardPins // Status pins
);
	// Seated card; ready once any nonzero Vcc code is requested
	always @(posedge clk) cardPins <= {vccIn != 2'h0, 5'h0c};
endmodule
`default_nettype wire

// file: test/test_pc_card_socket_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_pc_card_socket_power_control;
	import socket_power_pkg::*;
	logic clk = 0, sys_rst = 1, regWr = 0, regRd = 0, allow = 0, lv3 = 1;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic [5:0] pins;
	logic oe, auto;
	vcc_sel_t vcc;
	vpp_sel_t vpp;
	int mismatches = 0, checksDone = 0;
	pc_card_socket_power_control pc_card_socket_power_control_inst (
		.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .sysAutoSwitchAllow(allow),
		.sysVccLevel3v3(lv3), .ifStatusIn(pins), .regRdata(regRdata),
		.cardOutputEnable(oe), .autoSwitchEn(auto), .vccLevelSelect(vcc),
		.vppLevelSelect(vpp));
	socket_switch_model socket_switch_model_inst (.clk(clk), .vccIn(vcc),
		.cardPins(pins));
	initial forever #2.5 clk = ~clk;
	task automatic check(input logic [7:0] got, exp);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		regWr = 1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWr = 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge clk);
		regRd = 1;
		regAddr = a;
		@(negedge clk);
		regRd = 0;
		check(regRdata, e);
	endtask
	// Outputs land two edges after the write strobe
	task automatic outs(input logic [5:0] e);
		@(negedge clk);
		check({2'h0, oe, auto, vcc, vpp}, {2'h0, e});
	endtask
	task automatic test_reset;
		rd(12'h802, 8'h00);
		rd(12'h800, 8'h04);
		outs(6'h00);
		rd(12'h805, 8'h00);
	endtask
	task automatic test_newer;
		wr(12'h802, 8'hff);
		outs(6'h2f);
		rd(12'h802, 8'h9b);
		wr(12'h802, 8'h81);
		outs(6'h20);
		wr(12'h802, 8'h12);
		outs(6'h0a);
		rd(12'h801, 8'h6c);
	endtask
	task automatic test_older;
		wr(12'h800, 8'h02);
		allow = 1;
		wr(12'h802, 8'hff);
		rd(12'h802, 8'hb3);
		check({2'h0, oe, auto, vcc, vpp}, 8'h3f);
		wr(12'h802, 8'he1);
		outs(6'h30);
		wr(12'h800, 8'h04);
		rd(12'h802, 8'h81);
	endtask
	task automatic test_older_5v;
		wr(12'h800, 8'h02);
		allow = 0;
		lv3 = 0;
		wr(12'h802, 8'h31);
		outs(6'h09);
		rd(12'h801, 8'h6c);
	endtask
	task automatic test_reserved_bits_and_reset;
		wr(12'h800, 8'h04);
		wr(12'h802, 8'h89);
		outs(6'h24);
		rd(12'h801, 8'h2c);
		@(negedge clk);
		sys_rst = 1;
		repeat (10) @(negedge clk);
		sys_rst = 0;
		outs(6'h00);
		rd(12'h802, 8'h00);
		rd(12'h800, 8'h04);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(negedge clk);
		sys_rst = 0;
		test_reset;
		test_newer;
		test_older;
		test_older_5v;
		test_reserved_bits_and_reset;
		tally_and_finish;
	end
endmodule
`default_nettype wire
